// >>> design/nfc_bus_cycle.sv
`timescale 1ns/10ps
// one bus cycle on the flash pins: setup, strobe, release
module nfc_bus_cycle
(
    input  wire logic                      sys_clk,
    input  wire logic                      reset,
    input  wire logic                      start,
    input  wire logic                      is_read,
    input  wire logic [nfc_pkg::ADDR_W-1:0] addr,
    input  wire logic [nfc_pkg::DATA_W-1:0] wdata,
    input  wire logic [nfc_pkg::DATA_W-1:0] dq_in,
    output logic                           busy,
    output logic                           done,
    output logic [nfc_pkg::DATA_W-1:0]     rdata,
    output logic [nfc_pkg::ADDR_W-1:0]     addr_out,
    output logic [nfc_pkg::DATA_W-1:0]     dq_out,
    output logic                           dq_oe,
    output logic                           chip_en_n,
    output logic                           write_en_n,
    output logic                           out_en_n
);
    typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} nfc_bc_t;
    nfc_bc_t    st_r;
    logic [7:0] cnt_r;
    logic       rd_r;
    assign busy = (st_r != BC_IDLE);

    always_ff @(posedge sys_clk)
    begin
        done <= 1'b0;
        if (reset)
        begin
            st_r       <= BC_IDLE;
            cnt_r      <= 8'h00;
            rd_r       <= 1'b0;
            rdata      <= '0;
            addr_out   <= '0;
            dq_out     <= '0;
            dq_oe      <= 1'b0;
            chip_en_n  <= 1'b1;
            write_en_n <= 1'b1;
            out_en_n   <= 1'b1;
        end
        else
        begin
            case (st_r)
                BC_IDLE:
                    if (start)
                    begin
                        addr_out  <= addr;
                        dq_out    <= wdata;
                        rd_r      <= is_read;
                        dq_oe     <= !is_read;
                        chip_en_n <= 1'b0;
                        cnt_r     <= 8'(nfc_pkg::SETUP_CYC);
                        st_r      <= BC_SETUP;
                    end
                BC_SETUP:
                    if (cnt_r <= 8'h01)
                    begin
                        // separate strobes keep host and flash off the bus together
                        write_en_n <= rd_r;
                        out_en_n   <= !rd_r;
                        cnt_r      <= 8'(nfc_pkg::STROBE_CYC);
                        st_r       <= BC_STROBE;
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                BC_STROBE:
                    if (cnt_r <= 8'h01)
                    begin
                        if (rd_r)
                            rdata <= dq_in;
                        write_en_n <= 1'b1;
                        out_en_n   <= 1'b1;
                        st_r       <= BC_HOLD;
                    end
                    else
                        cnt_r <= cnt_r - 8'h01;
                default:
                begin
                    chip_en_n <= 1'b1;
                    dq_oe     <= 1'b0;
                    done      <= 1'b1;
                    st_r      <= BC_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> design/nfc_host.sv
`timescale 1ns/10ps
// Contract
// - commands are plain write cycles; flash latches address and data.
// - in bypass mode a byte program takes two writes, else four.
// - suspend holds erase; other sectors usable; resume continues. Host polls each erase to its end, so suspend is only sent after the erase.
// - host may place flash in standby by itself.
// - separate chip, write and output enables avoid bus contention.
// - twenty address lines select one byte.
// - hardware reset pin is active low.
module nfc_host
(
    input  wire logic                       sys_clk,
    input  wire logic                       reset,
    input  wire logic                       cmd_valid,
    input  wire nfc_pkg::nfc_cmd_t          cmd_op,
    input  wire logic [nfc_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [nfc_pkg::DATA_W-1:0] cmd_data,
    input  wire logic                       standby_req,
    output logic                            cmd_ready,
    output logic                            resp_valid,
    output logic [nfc_pkg::DATA_W-1:0]      resp_data,
    output logic                            op_busy,
    output logic                            bypass_active,
    input  wire logic                       ready_busy_out,
    input  wire logic [nfc_pkg::DATA_W-1:0] byte_data_lines_in,
    output logic [nfc_pkg::DATA_W-1:0]      byte_data_lines_out,
    output logic                            byte_data_lines_oe,
    output logic [nfc_pkg::ADDR_W-1:0]      byte_address_lines,
    output logic                            chip_en_n,
    output logic                            write_en_n,
    output logic                            out_en_n,
    output logic                            flash_reset_n
);
    typedef enum logic [2:0] {
        HS_RESET, HS_IDLE, HS_SEQ, HS_READ, HS_WAIT, HS_POLL
    } nfc_hs_t;

    nfc_hs_t                       st_r;
    logic [2:0]                    step_r;
    logic [2:0]                    last_r;
    nfc_pkg::nfc_cmd_t             op_r;
    logic [nfc_pkg::ADDR_W-1:0]    addr_r;
    logic [nfc_pkg::DATA_W-1:0]    data_r;
    logic [7:0]                    rst_cnt_r;
    logic                          bypass_r;
    logic                          toggle_prev_r;
    logic                          poll_first_r;
    logic                          resp_valid_r;
    logic [nfc_pkg::DATA_W-1:0]    resp_data_r;
    logic                          bc_start;
    logic                          bc_read;
    logic                          bc_busy;
    logic                          bc_done;
    logic [nfc_pkg::DATA_W-1:0]    bc_rdata;
    logic [nfc_pkg::DATA_W-1:0]    seq_data;
    logic [nfc_pkg::ADDR_W-1:0]    seq_addr;
    logic [nfc_pkg::ADDR_W-1:0]    bc_addr;
    logic [nfc_pkg::DATA_W-1:0]    bc_wdata;
    logic [2:0]                    seq_len;
    logic                          waits_done;
    logic                          toggled;
    logic                          bc_chip_en_n;
    logic                          bc_write_en_n;
    logic                          bc_out_en_n;

    // unlock writes go to address zero; any address is accepted by the flash
    function automatic logic [7:0] seq_byte(input nfc_pkg::nfc_cmd_t op, input logic [2:0] s,
                                            input logic byp, input logic [7:0] d);
        logic [7:0] b;
        b = 8'h00;
        if (s == 3'd0)
            b = nfc_pkg::UNLOCK1_DATA;
        else if (s == 3'd1)
            b = nfc_pkg::UNLOCK2_DATA;
        else if (s == 3'd2)
            b = (op == nfc_pkg::CMD_PROGRAM) ? nfc_pkg::PROG_DATA
              : (op == nfc_pkg::CMD_BYPASS_ENTER) ? nfc_pkg::BYPASS_DATA
              : nfc_pkg::ERASE_DATA;
        else if (s == 3'd3)
            b = (op == nfc_pkg::CMD_PROGRAM) ? d : nfc_pkg::UNLOCK1_DATA;
        else if (s == 3'd4)
            b = nfc_pkg::UNLOCK2_DATA;
        else
            b = (op == nfc_pkg::CMD_CHIP_ERASE) ? nfc_pkg::CHIP_DATA : nfc_pkg::SECT_DATA;
        if (op == nfc_pkg::CMD_PROGRAM && byp)
            b = (s == 3'd2) ? nfc_pkg::PROG_DATA : d;
        else if (op == nfc_pkg::CMD_BYPASS_EXIT)
            b = (s == 3'd0) ? nfc_pkg::BYP_EXIT1 : nfc_pkg::BYP_EXIT2;
        else if (op == nfc_pkg::CMD_SUSPEND)
            b = nfc_pkg::SUSPEND_DATA;
        else if (op == nfc_pkg::CMD_RESUME)
            b = nfc_pkg::RESUME_DATA;
        else if (op == nfc_pkg::CMD_RESET)
            b = nfc_pkg::RESET_DATA;
        return b;
    endfunction

    assign seq_len = (cmd_op == nfc_pkg::CMD_PROGRAM) ? (bypass_r ? 3'd2 : 3'd4)
                   : (cmd_op == nfc_pkg::CMD_CHIP_ERASE) ? 3'd6
                   : (cmd_op == nfc_pkg::CMD_SECTOR_ERASE) ? 3'd6
                   : (cmd_op == nfc_pkg::CMD_BYPASS_ENTER) ? 3'd3
                   : (cmd_op == nfc_pkg::CMD_BYPASS_EXIT) ? 3'd2
                   : 3'd1;
    // bypass program starts at the program-code step
    wire [2:0] seq_step = (op_r == nfc_pkg::CMD_PROGRAM && bypass_r) ? step_r + 3'd2 : step_r;
    assign seq_data = seq_byte(op_r, seq_step, bypass_r, data_r);
    // data and sector cycles carry the target address; sector address in top bits
    assign seq_addr = (step_r == last_r) ? addr_r : '0;
    assign bc_addr  = (st_r == HS_SEQ) ? seq_addr : addr_r;
    assign bc_wdata = seq_data;
    assign bc_read  = (st_r != HS_SEQ);
    assign bc_start = !bc_busy && !bc_done
                    && ((st_r == HS_SEQ) || (st_r == HS_READ) || (st_r == HS_POLL));
    assign waits_done = (op_r == nfc_pkg::CMD_PROGRAM) || (op_r == nfc_pkg::CMD_CHIP_ERASE)
                     || (op_r == nfc_pkg::CMD_SECTOR_ERASE) || (op_r == nfc_pkg::CMD_RESUME);
    assign toggled = bc_rdata[nfc_pkg::TOGGLE_BIT] != toggle_prev_r;

    assign cmd_ready     = (st_r == HS_IDLE);
    assign op_busy       = (st_r != HS_IDLE);
    assign bypass_active = bypass_r;
    assign resp_valid    = resp_valid_r;
    assign resp_data     = resp_data_r;
    // standby: deselect the chip while idle
    assign chip_en_n     = bc_chip_en_n | (standby_req && st_r == HS_IDLE);
    assign write_en_n    = bc_write_en_n;
    assign out_en_n      = bc_out_en_n;

    nfc_bus_cycle u_cycle
    (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .start      (bc_start),
        .is_read    (bc_read),
        .addr       (bc_addr),
        .wdata      (bc_wdata),
        .dq_in      (byte_data_lines_in),
        .busy       (bc_busy),
        .done       (bc_done),
        .rdata      (bc_rdata),
        .addr_out   (byte_address_lines),
        .dq_out     (byte_data_lines_out),
        .dq_oe      (byte_data_lines_oe),
        .chip_en_n  (bc_chip_en_n),
        .write_en_n (bc_write_en_n),
        .out_en_n   (bc_out_en_n)
    );

    always_ff @(posedge sys_clk)
    begin
        resp_valid_r <= 1'b0;
        if (reset)
        begin
            st_r          <= HS_RESET;
            rst_cnt_r     <= 8'(nfc_pkg::RESET_CYC);
            flash_reset_n <= 1'b0;
            step_r        <= 3'd0;
            last_r        <= 3'd0;
            op_r          <= nfc_pkg::CMD_NONE;
            addr_r        <= '0;
            data_r        <= '0;
            bypass_r      <= 1'b0;
            toggle_prev_r <= 1'b0;
            poll_first_r  <= 1'b0;
            resp_data_r   <= '0;
        end
        else
        begin
            case (st_r)
                HS_RESET:
                    // reset pulse aborts any flash operation
                    if (rst_cnt_r <= 8'h01)
                    begin
                        flash_reset_n <= 1'b1;
                        st_r          <= HS_IDLE;
                    end
                    else
                        rst_cnt_r <= rst_cnt_r - 8'h01;
                HS_IDLE:
                    if (cmd_valid)
                    begin
                        op_r   <= cmd_op;
                        addr_r <= cmd_addr;
                        data_r <= cmd_data;
                        step_r <= 3'd0;
                        last_r <= seq_len - 3'd1;
                        if (cmd_op == nfc_pkg::CMD_READ)
                            st_r <= HS_READ;
                        else if (cmd_op == nfc_pkg::CMD_NONE)
                            st_r <= HS_IDLE;
                        else
                            st_r <= HS_SEQ;
                    end
                HS_SEQ:
                    if (bc_done)
                    begin
                        if (step_r == last_r)
                        begin
                            if (op_r == nfc_pkg::CMD_BYPASS_ENTER)
                                bypass_r <= 1'b1;
                            else if (op_r == nfc_pkg::CMD_BYPASS_EXIT
                                     || op_r == nfc_pkg::CMD_RESET)
                                bypass_r <= 1'b0;
                            poll_first_r <= 1'b1;
                            // flash runs program/erase by itself; host only watches
                            st_r <= waits_done ? HS_WAIT : HS_IDLE;
                        end
                        else
                            step_r <= step_r + 3'd1;
                    end
                HS_READ:
                    if (bc_done)
                    begin
                        resp_data_r  <= bc_rdata;
                        resp_valid_r <= 1'b1;
                        st_r         <= HS_IDLE;
                    end
                HS_WAIT:
                    // ready pin may lag the last write; status reads settle it
                    st_r <= HS_POLL;
                HS_POLL:
                    if (bc_done)
                    begin
                        toggle_prev_r <= bc_rdata[nfc_pkg::TOGGLE_BIT];
                        poll_first_r  <= 1'b0;
                        // done once toggling stops and the ready pin is high
                        if (!poll_first_r && !toggled && ready_busy_out)
                        begin
                            resp_data_r  <= bc_rdata;
                            resp_valid_r <= 1'b1;
                            st_r         <= HS_IDLE;
                        end
                    end
                default:
                    st_r <= HS_IDLE;
            endcase
        end
    end
endmodule

// >>> design/nfc_pkg.sv
package nfc_pkg;
    localparam int ADDR_W        = 20;
    localparam int DATA_W        = 8;
    localparam int SECTOR_CNT    = 16;
    localparam int SECTOR_BIT    = 16;
    localparam int CLK_MHZ       = 50;
    localparam int T_SETUP_NS    = 70;
    localparam int T_STROBE_NS   = 50;
    localparam int T_RESET_NS    = 500;
    localparam int SETUP_CYC     = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC    = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_CYC     = (T_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int POLL_BIT      = 7;
    localparam int TOGGLE_BIT    = 6;
    localparam logic [7:0] UNLOCK1_DATA = 8'haa;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] PROG_DATA    = 8'ha0;
    localparam logic [7:0] ERASE_DATA   = 8'h80;
    localparam logic [7:0] CHIP_DATA    = 8'h10;
    localparam logic [7:0] SECT_DATA    = 8'h30;
    localparam logic [7:0] BYPASS_DATA  = 8'h20;
    localparam logic [7:0] BYP_EXIT1    = 8'h90;
    localparam logic [7:0] BYP_EXIT2    = 8'h00;
    localparam logic [7:0] SUSPEND_DATA = 8'hb0;
    localparam logic [7:0] RESUME_DATA  = 8'h30;
    localparam logic [7:0] RESET_DATA   = 8'hf0;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_PROGRAM, CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_BYPASS_ENTER,
        CMD_BYPASS_EXIT, CMD_SUSPEND, CMD_RESUME, CMD_RESET, CMD_READ
    } nfc_cmd_t;
endpackage

// >>> tb/nfc_flash_model.sv
`timescale 1ns/10ps
module nfc_flash_model
#(
    parameter logic [15:0] PROT_MASK   = 16'h8000,
    parameter bit          TEMP_UNPROT = 1'b0,
    parameter bit          LOW_VCC     = 1'b0,
    parameter int          BUSY_CYC    = 30
)
(
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  dq,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        rst_n,
    output logic             rdy,
    output logic [7:0]       q
);
    logic [7:0] mem [0:1048575];
    logic [7:0] last;
    logic [7:0] tgt;
    logic       byp;
    logic       tog;
    int         step;
    int         busy;
    int         idle_t;
    initial
    begin
        for (int k = 0; k < 1048576; k++)
            mem[k] = 8'hff;
        {step, busy, byp, tog, last, tgt} = '0;
    end
    always @(addr) idle_t = 0;
    always #20
    begin
        if (busy > 0) busy--;
        // sleep only saves power; reads still answer at once, so nothing waits on it
        if (idle_t < 50) idle_t++;
    end
    assign rdy = (busy == 0);
    always @(negedge rst_n)
    begin
        busy = 0;
        step = 0;
        byp = 0;
    end
    // decode looks at data only, so unlock cycles may land on any address
    always @(posedge we_n) if (!ce_n && rst_n && busy == 0 && !LOW_VCC)
        case (step)
            0: step = (dq == 8'haa) ? 1 : (byp && dq == 8'ha0) ? 5 : (byp && dq == 8'h90) ? 6 : 0;
            1: step = (dq == 8'h55) ? 2 : 0;
            2:
            begin
                if (dq == 8'h20) byp = 1;
                step = (dq == 8'ha0) ? 5 : (dq == 8'h80) ? 3 : 0;
            end
            3: step = (dq == 8'haa) ? 4 : 0;
            4: step = (dq == 8'h55) ? 7 : 0;
            5:
            begin
                if (!PROT_MASK[addr[19:16]] || TEMP_UNPROT) mem[addr] = dq;
                tgt = dq;
                busy = BUSY_CYC;
                step = 0;
            end
            6:
            begin
                byp = (dq != 8'h00);
                step = 0;
            end
            7:
            begin
                if (dq == 8'h10 || dq == 8'h30)
                begin
                    for (int k = 0; k < 1048576; k++)
                        if ((!PROT_MASK[k[19:16]] || TEMP_UNPROT)
                            && (dq == 8'h10 || k[19:16] == addr[19:16])) mem[k] = 8'hff;
                    tgt = 8'hff;
                    busy = BUSY_CYC;
                end
                step = 0;
            end
            default: step = 0;
        endcase
    always @(negedge oe_n) if (!ce_n)
    begin
        tog = !tog;
        last = (busy > 0) ? {~tgt[7], tog, 6'h00} : mem[addr];
    end
    // released bus shows the inverse so a stale byte is never mistaken for data
    assign q = (!ce_n && !oe_n) ? last : ~last;
endmodule

// >>> tb/nfc_host_checker.sv
`timescale 1ns/10ps
module nfc_host_checker
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        cmd_ready,
    input wire logic        resp_valid,
    input wire logic        op_busy,
    input wire logic        standby_req,
    input wire logic        byte_data_lines_oe,
    input wire logic [19:0] byte_address_lines,
    input wire logic [7:0]  byte_data_lines_out,
    input wire logic        chip_en_n,
    input wire logic        write_en_n,
    input wire logic        out_en_n,
    input wire logic        flash_reset_n
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_reset_pin_hold: assert property ($fell(reset) |-> !flash_reset_n ##20 !flash_reset_n)
        else $error("flash reset released too early");
    a_reset_no_cmd: assert property (!flash_reset_n |-> !cmd_ready)
        else $error("command accepted while flash held in reset");
    a_we_inside_ce: assert property (!write_en_n |-> !chip_en_n && out_en_n)
        else $error("write strobe without chip select or with output enable");
    a_no_contention: assert property (!out_en_n |-> !byte_data_lines_oe)
        else $error("host drives data while flash outputs");
    a_write_width: assert property ($fell(write_en_n) |-> !write_en_n [*3] ##1 write_en_n)
        else $error("write strobe width wrong");
    a_write_setup: assert property ($fell(write_en_n) |-> !$past(chip_en_n, 4) && byte_data_lines_oe)
        else $error("write strobe without setup");
    a_write_data_stable: assert property (!write_en_n && !$past(write_en_n)
        |-> $stable(byte_address_lines) && $stable(byte_data_lines_out))
        else $error("address or data moved under write strobe");
    a_read_width: assert property ($fell(out_en_n) |-> !out_en_n [*3] ##1 out_en_n)
        else $error("read strobe width wrong");
    a_resp_single: assert property (resp_valid |=> !resp_valid)
        else $error("response longer than one cycle");
    a_standby_ce: assert property (standby_req && $past(standby_req) && cmd_ready
        && $past(cmd_ready) |-> chip_en_n)
        else $error("chip selected during standby");
    // pin activity must only ever belong to an accepted command
    a_busy_refuse: assert property ((!chip_en_n || byte_data_lines_oe) |-> op_busy && !cmd_ready)
        else $error("flash pins active while host idle");

    c_resp: cover property ($rose(resp_valid));
    c_write: cover property ($fell(write_en_n));
    c_standby: cover property (standby_req && cmd_ready && chip_en_n);
endmodule

bind nfc_host nfc_host_checker u_nfc_host_checker (.sys_clk(sys_clk), .reset(reset),
    .cmd_ready(cmd_ready), .resp_valid(resp_valid), .op_busy(op_busy),
    .standby_req(standby_req), .byte_data_lines_oe(byte_data_lines_oe),
    .byte_address_lines(byte_address_lines), .byte_data_lines_out(byte_data_lines_out),
    .chip_en_n(chip_en_n), .write_en_n(write_en_n), .out_en_n(out_en_n),
    .flash_reset_n(flash_reset_n));

// >>> tb/nfc_host_tb.sv
`timescale 1ns/10ps
module nfc_host_tb;
    logic              sys_clk = 0;
    logic              reset = 1;
    logic              cmd_valid = 0;
    logic              standby_req = 0;
    nfc_pkg::nfc_cmd_t cmd_op = nfc_pkg::CMD_NONE;
    logic [19:0]       cmd_addr = 20'h00000;
    logic [7:0]        cmd_data = 8'h00;
    logic [7:0]        resp_data, dq_o, dq_i, fq;
    logic [19:0]       addr_o;
    logic              cmd_ready, resp_valid, op_busy, bypass_active, rdy;
    logic              dq_oe, ce_n, we_n, oe_n, frst_n;
    bit                saw_busy;
    int                n_errors = 0;
    int                tests_run = 0;
    int                n_wr = 0;
    int                n_resp = 0;
    logic [7:0]        last_wr;
    always #10 sys_clk = !sys_clk;
    always @(negedge we_n) n_wr++;
    always @(posedge we_n) last_wr = dq_i;
    always @(negedge sys_clk) if (resp_valid === 1'b1) n_resp++;
    always @(posedge sys_clk) if (rdy === 1'b0) saw_busy <= 1;
    assign dq_i = dq_oe ? dq_o : fq;
    nfc_host u_nfc_host (.sys_clk(sys_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .standby_req(standby_req),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
        .op_busy(op_busy), .bypass_active(bypass_active), .ready_busy_out(rdy),
        .byte_data_lines_in(dq_i), .byte_data_lines_out(dq_o), .byte_data_lines_oe(dq_oe),
        .byte_address_lines(addr_o), .chip_en_n(ce_n), .write_en_n(we_n), .out_en_n(oe_n),
        .flash_reset_n(frst_n));
    nfc_flash_model u_nfc_flash_model (.addr(addr_o), .dq(dq_i), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .rst_n(frst_n), .rdy(rdy), .q(fq));

    task automatic results();
        $display("tests_run %0d n_errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 3000 && cmd_ready !== 1'b1; i++)
            @(negedge sys_clk);
        if (cmd_ready !== 1'b1)
        begin
            n_errors++;
            $display("unexpected at %0t: host never idle", $time);
            results();
        end
    endtask
    task automatic issue(input nfc_pkg::nfc_cmd_t op, input logic [19:0] a, input logic [7:0] d);
        wait_idle();
        n_wr = 0;
        n_resp = 0;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1;
        @(negedge sys_clk);
        cmd_valid = 0;
        repeat (2) @(negedge sys_clk);
        wait_idle();
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] exp);
        issue(nfc_pkg::CMD_READ, a, 8'h00);
        check(resp_data, exp);
        check(8'(n_resp), 8'h01);
    endtask

    task automatic t_reset();
        check({7'h00, frst_n}, 8'h00);
        wait_idle();
        check({7'h00, frst_n}, 8'h01);
        $display("test reset done");
    endtask
    task automatic t_program();
        saw_busy = 0;
        issue(nfc_pkg::CMD_PROGRAM, 20'h12345, 8'h3c);
        check(8'(n_wr), 8'h04);
        check({7'h00, saw_busy}, 8'h01);
        rd(20'h12345, 8'h3c);
        issue(nfc_pkg::CMD_NONE, 20'h00000, 8'h00);
        check(8'(n_wr), 8'h00);
        $display("test program done");
    endtask
    task automatic t_bypass();
        issue(nfc_pkg::CMD_BYPASS_ENTER, 20'h00000, 8'h00);
        check({7'h00, bypass_active}, 8'h01);
        issue(nfc_pkg::CMD_PROGRAM, 20'h23456, 8'h5a);
        check(8'(n_wr), 8'h02);
        issue(nfc_pkg::CMD_BYPASS_EXIT, 20'h00000, 8'h00);
        check({7'h00, bypass_active}, 8'h00);
        rd(20'h23456, 8'h5a);
        $display("test bypass done");
    endtask
    task automatic t_erase();
        issue(nfc_pkg::CMD_SECTOR_ERASE, 20'h1ffff, 8'h00);
        check(8'(n_wr), 8'h06);
        rd(20'h12345, 8'hff);
        rd(20'h23456, 8'h5a);
        issue(nfc_pkg::CMD_PROGRAM, 20'hf0001, 8'h00);
        rd(20'hf0001, 8'hff);
        issue(nfc_pkg::CMD_CHIP_ERASE, 20'h00000, 8'h00);
        rd(20'h23456, 8'hff);
        issue(nfc_pkg::CMD_RESET, 20'h00000, 8'h00);
        check(8'(n_wr), 8'h01);
        $display("test erase done");
    endtask
    task automatic t_standby();
        standby_req = 1;
        repeat (4) @(negedge sys_clk);
        check({7'h00, ce_n}, 8'h01);
        standby_req = 0;
        rd(20'h00000, 8'hff);
        $display("test standby done");
    endtask
    task automatic t_suspend();
        issue(nfc_pkg::CMD_SUSPEND, 20'h00000, 8'h00);
        check(last_wr, 8'hb0);
        check(8'(n_wr), 8'h01);
        issue(nfc_pkg::CMD_RESUME, 20'h00000, 8'h00);
        check(last_wr, 8'h30);
        check(8'(n_resp), 8'h01);
        $display("test suspend done");
    endtask
    // reset lands while the flash is busy programming, after the last write
    task automatic t_hw_reset();
        wait_idle();
        cmd_op = nfc_pkg::CMD_PROGRAM;
        cmd_addr = 20'h00010;
        cmd_data = 8'h12;
        cmd_valid = 1;
        @(negedge sys_clk);
        cmd_valid = 0;
        for (int i = 0; i < 200 && rdy !== 1'b0; i++)
            @(negedge sys_clk);
        check({7'h00, rdy}, 8'h00);
        reset = 1;
        repeat (2) @(negedge sys_clk);
        reset = 0;
        @(negedge sys_clk);
        check({6'h00, frst_n, rdy}, 8'h01);
        wait_idle();
        check({7'h00, frst_n}, 8'h01);
        rd(20'h00010, 8'h12);
        $display("test hw reset done");
    endtask

    initial
    begin
        repeat (16) @(negedge sys_clk);
        reset = 0;
        @(negedge sys_clk);
        t_reset();
        t_program();
        t_bypass();
        t_erase();
        t_standby();
        t_suspend();
        t_hw_reset();
        results();
    end
endmodule
